// File: src/usr_pkg.sv
package usr_pkg;

    // Register geometry
    localparam int USR_STAGES = 8;
    localparam int USR_FIFO_DEPTH = 16;
    localparam int USR_CNT_W = 3;

    // Register byte offsets
    localparam logic [7:0] USR_CTRL_OFS = 8'h00;
    localparam logic [7:0] USR_STATUS_OFS = 8'h04;
    localparam logic [7:0] USR_FIFO_OFS = 8'h08;

    // Control field positions
    localparam int USR_CTRL_CAP_EN_BIT = 0;
    localparam int USR_CTRL_STEP_BIT = 1;
    localparam int USR_CTRL_OVR_CLR_BIT = 2;

    // Status and FIFO read field positions
    localparam int USR_STAT_STAGE_LSB = 0;
    localparam int USR_STAT_CNT_LSB = 8;
    localparam int USR_STAT_LVL_LSB = 16;
    localparam int USR_STAT_OVR_BIT = 24;
    localparam int USR_STAT_BIDIR_BIT = 25;
    localparam int USR_FIFO_VALID_BIT = 8;

    // Values after reset, and the shift count that completes a byte
    localparam logic [7:0] USR_STAGES_RST = 8'h00;
    localparam logic USR_CAP_EN_RST = 1'b0;
    localparam logic [2:0] USR_CNT_RST = 3'h0;
    localparam logic [31:0] USR_RDATA_RST = 32'h0000_0000;
    localparam logic [2:0] USR_LAST_SHIFT = 3'h7;

    // Operating modes
    typedef enum logic [1:0] {
        USR_HOLD,
        USR_SHIFT_UP,
        USR_SHIFT_DOWN,
        USR_LOAD
    } usr_mode_t;

    // Pins sampled together through the synchroniser
    typedef struct packed {
        logic mode_sel_lo;
        logic mode_sel_hi;
        logic right_serial_in;
        logic left_serial_in;
        logic shift_or_load_sel;
        logic entry_true_in;
        logic entry_inv_in;
        logic shift_clk_in;
        logic clock_gate_in;
        logic [7:0] par_in;
    } usr_pins_t;

endpackage

// File: src/usr_shift_reg.sv
// Summary of operation
// [R1] Bidirectional: both mode selects high loads all eight parallel inputs on clock rise.
// [R2] Stages change only after a rising clock edge, never on falls or levels. A software step through the control register also clocks them here.
// [R3] During parallel load all serial inputs are ignored.
// [R4] Low select high, high select low: shift toward last stage, right serial enters.
// [R5] Low select low, high select high: shift toward first stage, left serial enters.
// [R6] Both mode selects low: no stage is clocked, outputs hold.
// [R7] Driving logic changes mode selects only while the clock is high.
// [R8] Clear low forces all stages low at once, overriding everything.
// [R9] Unidirectional: shift/load low with clocking enabled loads parallel inputs.
// [R10] Unidirectional: shift/load high shifts each stage one place toward last.
// [R11] Unidirectional shift: first stage fed from true and inverted serial entries.
// [R12] Two clock inputs interchangeable; either high blocks, other rising clocks.
// [R13] Driving logic raises the clock gate only while the clock is high.
// [R14] A serial bit reaches the opposite end after exactly eight shifts.
// [R15] Entry table: 0/1 keep, 0/0 low, 1/1 high, 1/0 complement.
// [R16] Build parameter selects bidirectional or unidirectional control scheme.
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps

module usr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Fill level
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } usr_fifo_state_t;

    usr_fifo_state_t st;
    usr_fifo_state_t next_st;
    logic push;
    logic pop;

    // Handshake flags straight from the count
    assign in_ready = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign out_data = st.mem[st.rp];
    assign level = st.cnt;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and count update; depth is a power of two so pointers wrap freely
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = in_data;
            next_st.wp = st.wp + AW'(1);
        end
        if (pop) begin
            next_st.rp = st.rp + AW'(1);
        end
        if (push && !pop) begin
            next_st.cnt = st.cnt + (AW+1)'(1);
        end else if (pop && !push) begin
            next_st.cnt = st.cnt - (AW+1)'(1);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end
endmodule

module usr_shift_reg
    import usr_pkg::*;
#(
    parameter bit BIDIR = 1'b1
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Asynchronous clear, active low
    input wire logic clear_n,
    // Control and data pins
    input wire logic mode_sel_lo,
    input wire logic mode_sel_hi,
    input wire logic right_serial_in,
    input wire logic left_serial_in,
    input wire logic shift_or_load_sel,
    input wire logic entry_true_in,
    input wire logic entry_inv_in,
    input wire logic shift_clk_in,
    input wire logic clock_gate_in,
    input wire logic [7:0] par_in,
    // Stage outputs
    output logic [7:0] stage_out,
    output logic first_stage_out,
    output logic last_stage_out
);
    localparam int LVL_W = $clog2(USR_FIFO_DEPTH) + 1;

    typedef struct packed {
        usr_pins_t sync1;
        usr_pins_t sync2;
        logic clk_prev;
        logic gate_prev;
        logic cap_en;
        logic step_pend;
        logic [USR_CNT_W-1:0] shift_cnt;
        logic push_pend;
        logic [7:0] push_word;
        logic overrun;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } usr_state_t;

    usr_state_t st;
    usr_state_t next_st;
    logic [7:0] stages;
    logic [7:0] next_stages;
    usr_pins_t pins_raw;
    usr_pins_t p;
    usr_mode_t mode;
    logic clk_evt;
    logic stall;
    logic fifo_ready;
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic [LVL_W-1:0] fifo_level;
    logic fifo_pop;
    logic wr_done;
    logic rd_fifo;

    // Serial entry into the first stage from the true/inverted pair
    function automatic logic usr_entry(input logic t, input logic inv, input logic q);
        usr_entry = (t & ~q) | (inv & q); // [R15]
    endfunction

    // Mode from the sampled controls; the build parameter picks the scheme
    function automatic usr_mode_t usr_decode(input usr_pins_t pp);
        if (BIDIR) begin // [R16]
            unique case ({pp.mode_sel_hi, pp.mode_sel_lo})
                2'b00: usr_decode = USR_HOLD; // [R6]
                2'b01: usr_decode = USR_SHIFT_UP; // [R4]
                2'b10: usr_decode = USR_SHIFT_DOWN; // [R5]
                2'b11: usr_decode = USR_LOAD; // [R1]
            endcase
        end else begin
            usr_decode = pp.shift_or_load_sel ? USR_SHIFT_UP : USR_LOAD; // [R9] [R10]
        end
    endfunction

    assign pins_raw = '{
        mode_sel_lo: mode_sel_lo,
        mode_sel_hi: mode_sel_hi,
        right_serial_in: right_serial_in,
        left_serial_in: left_serial_in,
        shift_or_load_sel: shift_or_load_sel,
        entry_true_in: entry_true_in,
        entry_inv_in: entry_inv_in,
        shift_clk_in: shift_clk_in,
        clock_gate_in: clock_gate_in,
        par_in: par_in
    };
    assign p = st.sync2;
    assign mode = usr_decode(p);

    // Clocking event: a rising edge or a software step counts, never a level or a fall
    always_comb begin
        if (BIDIR) begin
            clk_evt = p.shift_clk_in && !st.clk_prev; // [R2]
        end else begin
            // Either pin may act as clock while the other is held low
            clk_evt = (p.shift_clk_in && !st.clk_prev && !p.clock_gate_in)
                || (p.clock_gate_in && !st.gate_prev && !p.shift_clk_in); // [R12]
        end
        clk_evt = clk_evt || st.step_pend;
    end

    // A finished byte still waiting for buffer room blocks further clocking
    assign stall = st.push_pend && !fifo_ready;

    // Stage next value
    always_comb begin
        next_stages = stages;
        if (clk_evt && !stall) begin
            unique case (mode)
                USR_HOLD: next_stages = stages; // [R6]
                USR_LOAD: next_stages = p.par_in; // [R1] [R3] [R9]
                USR_SHIFT_UP: begin
                    next_stages = {stages[6:0], 1'b0}; // [R4] [R10] [R14]
                    if (BIDIR) begin
                        next_stages[0] = p.right_serial_in; // [R4]
                    end else begin
                        next_stages[0] = usr_entry(p.entry_true_in, p.entry_inv_in,
                            stages[0]); // [R11]
                    end
                end
                USR_SHIFT_DOWN: next_stages = {p.left_serial_in, stages[7:1]}; // [R5] [R14]
            endcase
        end
    end

    // Clear is a pin acting without the clock; its release is not synchronised,
    // so drivers should let go of it away from a clocking edge
    always_ff @(posedge sys_clk or posedge rst or negedge clear_n) begin
        if (rst || !clear_n) begin
            stages <= USR_STAGES_RST; // [R8]
        end else if (ce) begin
            stages <= next_stages; // [R2]
        end
    end

    assign stage_out = stages;
    assign first_stage_out = stages[0];
    assign last_stage_out = stages[7];

    // APB decode: one wait state, effects at the completing edge
    assign wr_done = psel && penable && st.pready && pwrite;
    assign rd_fifo = psel && penable && st.pready && !pwrite && (paddr == USR_FIFO_OFS);
    assign fifo_pop = rd_fifo && fifo_valid;

    always_comb begin
        next_st = st;
        // Two flops on every pin except clear_n before anything reads it
        next_st.sync1 = pins_raw;
        next_st.sync2 = st.sync1;
        next_st.clk_prev = p.shift_clk_in;
        next_st.gate_prev = p.clock_gate_in;
        next_st.step_pend = 1'b0;

        // Shift counting and byte capture
        if (clk_evt && !stall && mode inside {USR_SHIFT_UP, USR_SHIFT_DOWN}) begin
            next_st.shift_cnt = st.shift_cnt + USR_CNT_W'(1); // [R14]
            if (st.cap_en && st.shift_cnt == USR_LAST_SHIFT) begin
                next_st.push_pend = 1'b1;
            end
        end
        if (st.push_pend && fifo_ready) begin
            next_st.push_pend = 1'b0;
        end
        next_st.push_word = next_stages;

        // Bus access phase
        if (psel && penable && !st.pready) begin
            next_st.pready = 1'b1;
            next_st.pslverr = 1'b0;
            unique case (paddr)
                USR_CTRL_OFS: begin
                    next_st.prdata = USR_RDATA_RST;
                    next_st.prdata[USR_CTRL_CAP_EN_BIT] = st.cap_en;
                end
                USR_STATUS_OFS: begin
                    next_st.prdata = USR_RDATA_RST;
                    next_st.prdata[USR_STAT_STAGE_LSB +: 8] = stages;
                    next_st.prdata[USR_STAT_CNT_LSB +: USR_CNT_W] = st.shift_cnt;
                    next_st.prdata[USR_STAT_LVL_LSB +: LVL_W] = fifo_level;
                    next_st.prdata[USR_STAT_OVR_BIT] = st.overrun;
                    next_st.prdata[USR_STAT_BIDIR_BIT] = BIDIR;
                end
                USR_FIFO_OFS: begin
                    next_st.prdata = USR_RDATA_RST;
                    next_st.prdata[7:0] = fifo_data;
                    next_st.prdata[USR_FIFO_VALID_BIT] = fifo_valid;
                end
                default: begin
                    next_st.prdata = USR_RDATA_RST;
                    next_st.pslverr = 1'b1;
                end
            endcase
        end else begin
            next_st.pready = 1'b0;
            next_st.pslverr = 1'b0;
        end

        // Register writes
        if (wr_done && paddr == USR_CTRL_OFS) begin
            next_st.cap_en = pwdata[USR_CTRL_CAP_EN_BIT];
            next_st.step_pend = pwdata[USR_CTRL_STEP_BIT];
            if (pwdata[USR_CTRL_OVR_CLR_BIT]) begin
                next_st.overrun = 1'b0;
            end
        end
        // Set after clear so a lost edge in the same cycle is still seen
        if (clk_evt && stall) begin
            next_st.overrun = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.cap_en <= USR_CAP_EN_RST;
            st.shift_cnt <= USR_CNT_RST;
            st.prdata <= USR_RDATA_RST;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign prdata = st.prdata;

    // Captured bytes wait here for software
    usr_fifo #(
        .WIDTH(8),
        .DEPTH(USR_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .in_valid(st.push_pend),
        .in_ready(fifo_ready),
        .in_data(st.push_word),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data),
        .level(fifo_level)
    );
endmodule

// File: dv/usr_shift_mon_monitor.sv
`timescale 1ns/1ps
module usr_shift_mon #(
    parameter bit BIDIR = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Bus side
    input wire logic psel, penable, pready, pslverr,
    input wire logic [7:0] paddr,
    // Pins and stages
    input wire logic clear_n, mode_sel_lo, mode_sel_hi,
    input wire logic right_serial_in, left_serial_in, shift_or_load_sel,
    input wire logic entry_true_in, entry_inv_in, shift_clk_in, clock_gate_in,
    input wire logic [7:0] par_in,
    input wire logic [7:0] stage_out
);
    logic clk_q, gate_q, ev_b, ev_u;
    logic [7:0] prev;
    // Pin history starts low, as the design's own history does
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clk_q <= 1'b0;
            gate_q <= 1'b0;
            prev <= 8'h00;
        end else begin
            clk_q <= shift_clk_in;
            gate_q <= clock_gate_in;
            prev <= stage_out;
        end
    end
    // Clocking events seen at the pins
    assign ev_b = BIDIR && clear_n && shift_clk_in && !clk_q;
    assign ev_u = !BIDIR && clear_n && ((shift_clk_in && !clk_q && !clock_gate_in)
        || (clock_gate_in && !gate_q && !shift_clk_in));
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_clear_low: assert property (!clear_n |-> stage_out == 8'h00)
        else $error("stages not cleared");
    a_bidir_load: assert property (ev_b && mode_sel_lo && mode_sel_hi |->
        ##3 stage_out == $past(par_in, 3)) else $error("bad bidir load");
    a_shift_up: assert property (ev_b && mode_sel_lo && !mode_sel_hi |->
        ##3 stage_out == {prev[6:0], $past(right_serial_in, 3)}) else $error("bad up shift");
    a_shift_down: assert property (ev_b && !mode_sel_lo && mode_sel_hi |->
        ##3 stage_out == {$past(left_serial_in, 3), prev[7:1]}) else $error("bad down shift");
    a_uni_load: assert property (ev_u && !shift_or_load_sel |->
        ##3 stage_out == $past(par_in, 3)) else $error("bad unidir load");
    a_uni_shift: assert property (ev_u && shift_or_load_sel |-> ##3
        stage_out == {prev[6:0], ($past(entry_true_in, 3) & ~prev[0])
        | ($past(entry_inv_in, 3) & prev[0])}) else $error("bad unidir shift");
    a_apb_wait: assert property (psel && !penable |-> ##1 !pready ##1 pready)
        else $error("bus answer late");
    a_slverr_map: assert property (psel && penable && pready |->
        pslverr == !(paddr inside {8'h00, 8'h04, 8'h08})) else $error("bad error flag");
    c_load: cover property (ev_b && mode_sel_lo && mode_sel_hi);
    c_uni: cover property (ev_u && shift_or_load_sel);
    c_err: cover property (pready && pslverr);
endmodule
bind usr_shift_reg usr_shift_mon #(.BIDIR(BIDIR)) u_mon (.*);

// File: dv/usr_pin_drv.sv
`timescale 1ns/1ps
module usr_pin_drv import usr_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Request
    input wire logic go,
    input wire logic swap,
    input wire logic slow,
    input wire usr_pins_t cfg,
    // Pins
    output usr_pins_t pins,
    output logic busy
);
    int cnt;
    logic sw, slw, lo_ph;
    usr_pins_t held;
    // Idle clock rests high, so pins only change in the high phase
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            sw <= 1'b0;
            slw <= 1'b0;
            held <= '0;
        end else if (go && cnt == 0) begin
            cnt <= slow ? 20 : 12;
            sw <= swap;
            slw <= slow;
            held <= cfg;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    // High 3, low 4 or 12, high 5: every level outlasts the synchroniser
    assign lo_ph = cnt > 5 && cnt <= (slw ? 17 : 9);
    assign busy = cnt != 0;
    // Swap makes the gate pin the clock
    always_comb begin
        pins = held;
        pins.shift_clk_in = sw ? held.shift_clk_in : !lo_ph;
        pins.clock_gate_in = sw ? !lo_ph : held.clock_gate_in;
    end
endmodule

// File: dv/usr_shift_reg_test.sv
`timescale 1ns/1ps
module usr_shift_reg_test import usr_pkg::*; ;
    logic sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, clear_n = 1'b1, go = 1'b0, swap = 1'b0, slow = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, prdata_u, rd, ru, lfsr = 32'h06ef;
    logic pready, pslverr, busy, err;
    logic mode_sel_lo, mode_sel_hi, right_serial_in, left_serial_in, shift_or_load_sel;
    logic entry_true_in, entry_inv_in, shift_clk_in, clock_gate_in;
    logic first_stage_out, last_stage_out, fo_u, lo_u;
    logic [7:0] par_in, stage_out, st_u, e;
    logic [7:0] ex [2];
    logic [7:0] mb [2][17];
    int cs [2];
    int n_fail = 0, checks = 0, cyc = 0, k, j, nv, cn;
    usr_pins_t cfg = '0, pins, p;
    // Pins from the far-side model feed both variants
    assign {mode_sel_lo, mode_sel_hi, right_serial_in, left_serial_in, shift_or_load_sel,
        entry_true_in, entry_inv_in, shift_clk_in, clock_gate_in, par_in} = pins;
    usr_pin_drv drv (.*);
    usr_shift_reg #(.BIDIR(1'b1)) uut (.*);
    usr_shift_reg #(.BIDIR(1'b0)) uut_u (.*, .prdata(prdata_u), .pready(), .pslverr(),
        .stage_out(st_u), .first_stage_out(fo_u), .last_stage_out(lo_u));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end
    function automatic logic [31:0] f_lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Expected next stages for one clocking event
    function automatic logic [7:0] f_next(input bit bd, input usr_pins_t s, input logic [7:0] v);
        if (bd) begin
            case ({s.mode_sel_hi, s.mode_sel_lo})
                2'b01: return {v[6:0], s.right_serial_in};
                2'b10: return {s.left_serial_in, v[7:1]};
                2'b11: return s.par_in;
                default: return v;
            endcase
        end
        if (!s.shift_or_load_sel) return s.par_in;
        return {v[6:0], (s.entry_true_in & ~v[0]) | (s.entry_inv_in & v[0])};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] want, input string m);
        checks++;
        if (got !== want) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h want %h", $time, m, got, want);
        end
    endtask
    task automatic test_done();
        if (n_fail == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // One bus transfer; an idle cycle follows so strobes never collide
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        // No local limit: only the hang guard ends a wait that never finishes
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        rd = prdata;
        ru = prdata_u;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic pulse(input usr_pins_t s, input logic sw);
        cfg <= s;
        swap <= sw;
        slow <= lfsr[20];
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        @(posedge sys_clk);
        while (busy !== 1'b0) begin
            @(posedge sys_clk);
        end
        // Shift events also advance each variant's shift count
        if (!sw) begin
            ex[0] = f_next(1'b1, s, ex[0]);
            cs[0] = cs[0] + int'(s.mode_sel_hi ^ s.mode_sel_lo);
        end
        if (!(sw ? s.shift_clk_in : s.clock_gate_in)) begin
            ex[1] = f_next(1'b0, s, ex[1]);
            cs[1] = cs[1] + int'(s.shift_or_load_sel);
        end
        chk(stage_out, ex[0], "bidir stages");
        chk(st_u, ex[1], "unidir stages");
    endtask
    initial begin
        ex[0] = 8'h00;
        ex[1] = 8'h00;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0200_0000, "status");
        chk(ru, 32'h0, "unidir status");
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0, "control");
        apb(1'b0, 8'h0c, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped");
        // Single one walked end to end
        for (k = 0; k < 8; k++) begin
            p = '0;
            p.mode_sel_lo = 1'b1;
            p.shift_or_load_sel = 1'b1;
            p.right_serial_in = k == 0;
            p.entry_true_in = k == 0;
            p.entry_inv_in = k == 0;
            pulse(p, 1'b0);
        end
        chk({first_stage_out, last_stage_out, fo_u, lo_u}, 4'h5, "far end");
        // Every bidirectional mode first, then random pins
        for (k = 0; k < 48; k++) begin
            lfsr = f_lfsr(lfsr);
            p = usr_pins_t'(lfsr[16:0]);
            if (k < 4) {p.mode_sel_hi, p.mode_sel_lo} = k[1:0];
            pulse(p, 1'b0);
        end
        p = '0;
        p.mode_sel_lo = 1'b1;
        p.right_serial_in = 1'b1;
        p.shift_or_load_sel = 1'b1;
        p.entry_true_in = 1'b1;
        pulse(p, 1'b0);
        apb(1'b0, 8'h04, 32'h0);
        chk({rd[10:8], ru[10:8]}, {cs[0][2:0], cs[1][2:0]}, "shift count");
        // Software steps with capture on, no reads: the buffer fills and refuses
        for (k = 0; k < 137; k++) apb(1'b1, 8'h00, 32'h3);
        // Sixteen buffered bytes plus one held back; later steps are dropped
        for (j = 0; j < 2; j++) begin
            e = ex[j];
            cn = cs[j] % 8;
            nv = 0;
            for (k = 0; k < 137; k++) begin
                if (nv < 17) begin
                    e = f_next(j == 0, p, e);
                    cn = (cn + 1) % 8;
                    if (cn == 0) begin
                        mb[j][nv] = e;
                        nv++;
                    end
                end
            end
            ex[j] = e;
        end
        apb(1'b0, 8'h04, 32'h0);
        chk({rd[24], rd[20:16], ru[24], ru[20:16]}, {2{1'b1, 5'd16}}, "full with overrun");
        // Every read pops both buffers, so both drain side by side
        for (k = 0; k < 18; k++) begin
            apb(1'b0, 8'h08, 32'h0);
            chk({rd[8], ru[8]}, {2{k < 17}}, "byte valid");
            if (k < 17) begin
                chk({rd[7:0], ru[7:0]}, {mb[0][k], mb[1][k]}, "captured byte");
            end
        end
        apb(1'b1, 8'h00, 32'h4);
        apb(1'b0, 8'h04, 32'h0);
        chk({rd[24], rd[20:16], rd[10:8]}, 9'h0, "overrun cleared");
        chk({ru[24], ru[20:16], ru[10:8]}, 9'h0, "unidir overrun cleared");
        chk({stage_out, st_u}, {ex[0], ex[1]}, "stages after steps");
        // Clear acts between clock edges
        clear_n <= 1'b0;
        #1;
        chk({stage_out, st_u}, 16'h0, "async clear");
        @(posedge sys_clk);
        clear_n <= 1'b1;
        ex[0] = 8'h00;
        ex[1] = 8'h00;
        p.clock_gate_in = 1'b1;
        pulse(p, 1'b0);
        p.clock_gate_in = 1'b0;
        pulse(p, 1'b1);
        pulse(p, 1'b1);
        test_done();
    end
endmodule
